// ==== ssf_pkg.sv ====
// Constants, field layouts and carrier types for the serial status flags.
// Assumes one 125 MHz clock and shift engines on that same clock.
// What this block does
// - Received frame multiproc bit 1 sets, 0 clears the received multiproc flag.
// - Transmit multiproc control 1 sends frames with multiproc bit 1.
// - Transmit multiproc control 0 sends frames with multiproc bit 0.
// - Last bit shifted out while tx empty reads 1 sets tx done.
// - Transmitter disabled holds tx empty and tx done at 1.
// - Read tx empty as 1 then write 0 clears it and tx done.
// - Block mover write to tx holding register clears tx empty and done.
// - Holding byte moving into shift register sets tx empty.
// - Received parity disagreeing with selected odd or even sets parity flag.
// - Stop bit sampled 0 at frame end sets framing error flag.
// - Frame completing while rx full is 1 sets overrun flag.
// - Error-free reception while rx full is 0 moves byte to holding register, sets rx full.
// - Block mover reading rx holding register clears rx full.
// - Writing 0 only requests a clear; writing 1 never sets a flag.
package ssf_pkg;

  localparam int unsigned SSF_DW = 8;
  localparam int unsigned SSF_AW = 3;
  localparam int unsigned SSF_IW = 4;

  // Register offsets on the plain register port.
  localparam logic [SSF_AW-1:0] SSF_ADDR_STATUS = 3'h0;
  localparam logic [SSF_AW-1:0] SSF_ADDR_CTRL = 3'h1;
  localparam logic [SSF_AW-1:0] SSF_ADDR_MODE = 3'h2;
  localparam logic [SSF_AW-1:0] SSF_ADDR_TX_HOLD = 3'h3;
  localparam logic [SSF_AW-1:0] SSF_ADDR_RX_HOLD = 3'h4;
  localparam logic [SSF_AW-1:0] SSF_ADDR_IRQ_STAT = 3'h5;
  localparam logic [SSF_AW-1:0] SSF_ADDR_IRQ_MASK = 3'h6;

  // Status register field positions.
  localparam int unsigned SSF_TX_EMPTY = 7;
  localparam int unsigned SSF_RX_FULL = 6;
  localparam int unsigned SSF_OVERRUN = 5;
  localparam int unsigned SSF_FRAME_ERR = 4;
  localparam int unsigned SSF_PARITY_ERR = 3;
  localparam int unsigned SSF_TX_DONE = 2;
  localparam int unsigned SSF_MP_RX = 1;
  localparam int unsigned SSF_MP_TX = 0;

  // Flags cleared by the read-one then write-zero sequence.
  localparam int unsigned SSF_CLR_LO = 3;
  localparam logic [SSF_DW-1:0] SSF_STATUS_RESET = 8'h84;

  // Control and mode fields.
  localparam int unsigned SSF_CTRL_TX_EN = 0;
  localparam logic [SSF_DW-1:0] SSF_CTRL_RESET = 8'h00;
  localparam int unsigned SSF_MODE_PAR_EN = 0;
  localparam int unsigned SSF_MODE_PAR_ODD = 1;
  localparam int unsigned SSF_MODE_MP_EN = 2;
  localparam logic [SSF_DW-1:0] SSF_MODE_RESET = 8'h00;

  // Interrupt status and mask layout.
  localparam int unsigned SSF_IRQ_TX_EMPTY = 0;
  localparam int unsigned SSF_IRQ_TX_DONE = 1;
  localparam int unsigned SSF_IRQ_RX_FULL = 2;
  localparam int unsigned SSF_IRQ_ERROR = 3;

  // One received frame as handed over by the receive shift engine.
  typedef struct packed {
    logic [SSF_DW-1:0] data;
    logic parity_bit;
    logic stop_bit;
    logic mp_bit;
  } ssf_rx_frame_t;

  // Verdict on a received frame.
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic mp_bit;
  } ssf_rx_check_t;

  // Complete state of the top module.
  typedef struct packed {
    logic [SSF_DW-1:0] status;
    logic [SSF_DW-1:0] arm;
    logic [SSF_DW-1:0] ctrl;
    logic [SSF_DW-1:0] mode;
    logic [SSF_DW-1:0] tx_hold;
    logic [SSF_DW-1:0] rx_hold;
    logic [SSF_DW-1:0] rd_data;
    logic [SSF_IW-1:0] irq_stat;
    logic [SSF_IW-1:0] irq_mask;
    logic irq;
    logic tx_hold_irq;
    logic rx_hold_irq;
  } ssf_state_t;

endpackage : ssf_pkg

// ==== ssf_rx_check.sv ====
// Judges one received frame: parity, stop bit and multiproc bit.
// Assumes the frame fields are stable while the done pulse is high.
`timescale 1ns/10ps
module ssf_rx_check
  import ssf_pkg::*;
(
  input wire ssf_rx_frame_t frame,
  input wire logic par_en,
  input wire logic par_odd,
  output ssf_rx_check_t verdict
);

  logic ones_odd;

  // Odd count of ones over data plus parity means odd parity holds.
  always_comb begin
    ones_odd = ^{frame.data, frame.parity_bit};
    verdict.parity_err = par_en & (ones_odd != par_odd);
    verdict.frame_err = ~frame.stop_bit;
    verdict.mp_bit = frame.mp_bit;
  end

endmodule : ssf_rx_check

// ==== ssf_top.sv ====
// Status flag logic of one asynchronous serial channel with its registers.
// Assumes shift engines and block mover run on sys_clk and send pulses.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps
module ssf_top
  import ssf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [SSF_AW-1:0] reg_addr,
  input wire logic [SSF_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SSF_DW-1:0] reg_rdata,
  input wire logic tx_load,
  input wire logic tx_last_bit,
  input wire logic rx_done,
  input wire ssf_rx_frame_t rx_frame,
  input wire logic mover_tx_wr,
  input wire logic [SSF_DW-1:0] mover_tx_data,
  input wire logic mover_rx_rd,
  output logic [SSF_DW-1:0] tx_hold_data,
  output logic [SSF_DW-1:0] rx_hold_data,
  output logic tx_frame_mp,
  output logic tx_enable,
  output logic tx_empty_flag,
  output logic rx_full_flag,
  output logic tx_hold_irq,
  output logic rx_hold_irq,
  output logic irq
);

  ssf_state_t s_q;
  ssf_state_t s_d;
  ssf_rx_check_t rx_chk;
  logic wr_status;
  logic [SSF_DW-1:0] clr;
  logic [SSF_IW-1:0] irq_ev;
  logic tx_en;
  logic rx_any_err;
  logic rx_accept;

  // Register hit test, shared by the write and read decoders.
  function automatic logic reg_hit(
    input logic strobe,
    input logic [SSF_AW-1:0] addr,
    input logic [SSF_AW-1:0] target
  );
    reg_hit = strobe & (addr == target);
  endfunction : reg_hit

  // Parity, stop and multiproc judgement of the incoming frame.
  ssf_rx_check u_rx_check (
    .frame(rx_frame),
    .par_en(s_q.mode[SSF_MODE_PAR_EN]),
    .par_odd(s_q.mode[SSF_MODE_PAR_ODD]),
    .verdict(rx_chk)
  );

  // A clear needs a prior read that saw the flag at 1; a written 1 is
  // simply ignored, so software cannot forge a flag.
  always_comb begin
    wr_status = reg_hit(reg_wr, reg_addr, SSF_ADDR_STATUS);
    tx_en = s_q.ctrl[SSF_CTRL_TX_EN];
    clr = '0;
    for (int i = SSF_CLR_LO; i < SSF_DW; i++) begin
      clr[i] = wr_status & s_q.arm[i] & ~reg_wdata[i];
    end
    rx_any_err = rx_chk.parity_err | rx_chk.frame_err;
    rx_accept = rx_done & ~rx_any_err & ~s_q.status[SSF_RX_FULL];
  end

  // Next state: flags, registers, interrupt bookkeeping.
  always_comb begin
    s_d = s_q;
    irq_ev = '0;

    // Arm flags on a status read; a status write spends the arming unless a status read comes in the same cycle.
    if (reg_hit(reg_rd, reg_addr, SSF_ADDR_STATUS)) begin
      s_d.arm = s_q.status;
    end else if (wr_status) begin
      s_d.arm = '0;
    end

    // Software-owned fields.
    if (wr_status) begin
      s_d.status[SSF_MP_TX] = reg_wdata[SSF_MP_TX];
    end
    if (reg_hit(reg_wr, reg_addr, SSF_ADDR_CTRL)) begin
      s_d.ctrl = reg_wdata;
    end
    if (reg_hit(reg_wr, reg_addr, SSF_ADDR_MODE)) begin
      s_d.mode = reg_wdata;
    end
    if (reg_hit(reg_wr, reg_addr, SSF_ADDR_IRQ_MASK)) begin
      s_d.irq_mask = reg_wdata[SSF_IW-1:0];
    end
    if (reg_hit(reg_wr, reg_addr, SSF_ADDR_TX_HOLD)) begin
      s_d.tx_hold = reg_wdata;
    end

    // Transmit holding byte from the block mover.
    if (mover_tx_wr) begin
      s_d.tx_hold = mover_tx_data;
    end

    // Transmit empty: setting terms are tested first so they win.
    if (!tx_en) begin
      s_d.status[SSF_TX_EMPTY] = 1'b1;
    end else if (tx_load) begin
      s_d.status[SSF_TX_EMPTY] = 1'b1;
    end else if (clr[SSF_TX_EMPTY] || mover_tx_wr) begin
      s_d.status[SSF_TX_EMPTY] = 1'b0;
    end

    // Transmit done follows the empty flag's clearing events.
    if (!tx_en) begin
      s_d.status[SSF_TX_DONE] = 1'b1;
    end else if (tx_last_bit && s_q.status[SSF_TX_EMPTY]) begin
      s_d.status[SSF_TX_DONE] = 1'b1;
    end else if (clr[SSF_TX_EMPTY] || mover_tx_wr) begin
      s_d.status[SSF_TX_DONE] = 1'b0;
    end

    // Receive full and holding byte.
    if (rx_accept) begin
      s_d.rx_hold = rx_frame.data;
      s_d.status[SSF_RX_FULL] = 1'b1;
    end else if (clr[SSF_RX_FULL] || mover_rx_rd) begin
      s_d.status[SSF_RX_FULL] = 1'b0;
    end

    // Overrun: the holding byte is kept, the new frame is lost.
    if (rx_done && s_q.status[SSF_RX_FULL]) begin
      s_d.status[SSF_OVERRUN] = 1'b1;
    end else if (clr[SSF_OVERRUN]) begin
      s_d.status[SSF_OVERRUN] = 1'b0;
    end

    // Framing error from the sampled stop bit.
    if (rx_done && rx_chk.frame_err) begin
      s_d.status[SSF_FRAME_ERR] = 1'b1;
    end else if (clr[SSF_FRAME_ERR]) begin
      s_d.status[SSF_FRAME_ERR] = 1'b0;
    end

    // Parity mismatch.
    if (rx_done && rx_chk.parity_err) begin
      s_d.status[SSF_PARITY_ERR] = 1'b1;
    end else if (clr[SSF_PARITY_ERR]) begin
      s_d.status[SSF_PARITY_ERR] = 1'b0;
    end

    // Received multiproc bit tracks each frame in multiproc format.
    if (rx_done && s_q.mode[SSF_MODE_MP_EN]) begin
      s_d.status[SSF_MP_RX] = rx_chk.mp_bit;
    end

    // Rising tx empty, tx done and rx full flags are events; every bad or overrun frame is an error event.
    irq_ev[SSF_IRQ_TX_EMPTY] = s_d.status[SSF_TX_EMPTY]
      & ~s_q.status[SSF_TX_EMPTY];
    irq_ev[SSF_IRQ_TX_DONE] = s_d.status[SSF_TX_DONE]
      & ~s_q.status[SSF_TX_DONE];
    irq_ev[SSF_IRQ_RX_FULL] = s_d.status[SSF_RX_FULL]
      & ~s_q.status[SSF_RX_FULL];
    irq_ev[SSF_IRQ_ERROR] = rx_done & (rx_any_err
      | s_q.status[SSF_RX_FULL]);

    // Write one to clear; a new event in the same cycle keeps its bit.
    for (int i = 0; i < SSF_IW; i++) begin
      if (irq_ev[i]) begin
        s_d.irq_stat[i] = 1'b1;
      end else if (reg_hit(reg_wr, reg_addr, SSF_ADDR_IRQ_STAT)
                   && reg_wdata[i]) begin
        s_d.irq_stat[i] = 1'b0;
      end
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // Requests toward the block mover follow the live flags, tx empty only while tx is enabled.
    s_d.tx_hold_irq = s_d.status[SSF_TX_EMPTY] & s_d.ctrl[SSF_CTRL_TX_EN];
    s_d.rx_hold_irq = s_d.status[SSF_RX_FULL];

    // Read data appear in the cycle after the strobe and only then.
    s_d.rd_data = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        SSF_ADDR_STATUS: s_d.rd_data = s_q.status;
        SSF_ADDR_CTRL: s_d.rd_data = s_q.ctrl;
        SSF_ADDR_MODE: s_d.rd_data = s_q.mode;
        SSF_ADDR_TX_HOLD: s_d.rd_data = s_q.tx_hold;
        SSF_ADDR_RX_HOLD: s_d.rd_data = s_q.rx_hold;
        SSF_ADDR_IRQ_STAT: begin
          s_d.rd_data = {{(SSF_DW-SSF_IW){1'b0}}, s_q.irq_stat};
        end
        SSF_ADDR_IRQ_MASK: begin
          s_d.rd_data = {{(SSF_DW-SSF_IW){1'b0}}, s_q.irq_mask};
        end
        default: s_d.rd_data = '0;
      endcase
    end
  end

  // The single state register; reset values are constants only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q.status <= SSF_STATUS_RESET;
      s_q.arm <= '0;
      s_q.ctrl <= SSF_CTRL_RESET;
      s_q.mode <= SSF_MODE_RESET;
      s_q.tx_hold <= '0;
      s_q.rx_hold <= '0;
      s_q.rd_data <= '0;
      s_q.irq_stat <= '0;
      s_q.irq_mask <= '0;
      s_q.irq <= 1'b0;
      s_q.tx_hold_irq <= 1'b0;
      s_q.rx_hold_irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a flop of the state register.
  assign reg_rdata = s_q.rd_data;
  assign tx_hold_data = s_q.tx_hold;
  assign rx_hold_data = s_q.rx_hold;
  assign tx_frame_mp = s_q.status[SSF_MP_TX];
  assign tx_enable = s_q.ctrl[SSF_CTRL_TX_EN];
  assign tx_empty_flag = s_q.status[SSF_TX_EMPTY];
  assign rx_full_flag = s_q.status[SSF_RX_FULL];
  assign tx_hold_irq = s_q.tx_hold_irq;
  assign rx_hold_irq = s_q.rx_hold_irq;
  assign irq = s_q.irq;

endmodule : ssf_top

// ==== ssf_station.sv ====
// Remote serial station that hands finished frames to the receiver side.
// Assumes the bench pulses go with the frame to send; one clock domain.
`timescale 1ns/10ps
module ssf_station
  import ssf_pkg::*;
#(
  parameter int GAP = 3
)
(
  input wire logic sys_clk,
  input wire logic go,
  input wire ssf_rx_frame_t frm,
  output logic rx_done,
  output ssf_rx_frame_t rx_frame
);
  int cnt = 0;
  ssf_rx_frame_t hold = '0;
  // Outside the done cycle the fields show the inverse, not stale data.
  always @(posedge sys_clk) begin
    rx_done <= 1'b0;
    rx_frame <= ~hold;
    if (go) begin
      hold <= frm;
      cnt <= GAP;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      rx_done <= 1'b1;
      rx_frame <= hold;
    end
  end
endmodule : ssf_station

// ==== ssf_assertions.sv ====
// Concurrent checks on the ports of the serial status flag block.
// Assumes it is bound into ssf_top; one clock, synchronous reset.
`timescale 1ns/10ps
module ssf_checker
  import ssf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [SSF_AW-1:0] reg_addr,
  input wire logic [SSF_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic tx_load,
  input wire logic rx_done,
  input wire logic mover_tx_wr,
  input wire logic mover_rx_rd,
  input wire logic [SSF_DW-1:0] rx_hold_data,
  input wire logic tx_frame_mp,
  input wire logic tx_enable,
  input wire logic tx_empty_flag,
  input wire logic rx_full_flag,
  input wire logic rx_hold_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic st_wr;
  // Status writes are the only software path that clears the flags.
  assign st_wr = reg_wr && reg_addr == SSF_ADDR_STATUS;
  property p_off; !tx_enable |=> tx_empty_flag; endproperty
  a_off: assert property (p_off) else $error("tx empty low while off");
  property p_load; tx_load |=> tx_empty_flag; endproperty
  a_load: assert property (p_load) else $error("load left empty low");
  property p_mover;
    mover_tx_wr && tx_enable && !tx_load && !reg_wr |=> !tx_empty_flag;
  endproperty
  a_mover: assert property (p_mover) else $error("mover kept empty");
  property p_mp; st_wr |=> tx_frame_mp == $past(reg_wdata[SSF_MP_TX]);
  endproperty
  a_mp: assert property (p_mp) else $error("tx multiproc bit wrong");
  property p_ovr; rx_done && rx_full_flag && !mover_rx_rd && !reg_wr
    |=> rx_full_flag && $stable(rx_hold_data); endproperty
  a_ovr: assert property (p_ovr) else $error("overrun frame moved");
  property p_rise; $rose(rx_full_flag) |-> $past(rx_done) && rx_hold_irq;
  endproperty
  a_rise: assert property (p_rise) else $error("rx full rose alone");
  property p_mrd; mover_rx_rd && !rx_done |=> !rx_full_flag; endproperty
  a_mrd: assert property (p_mrd) else $error("mover read kept full");
  property p_one; st_wr && reg_wdata[SSF_RX_FULL] && !rx_full_flag
    && !rx_done |=> !rx_full_flag; endproperty
  a_one: assert property (p_one) else $error("write of one set flag");
  c_ovr: cover property (rx_done && rx_full_flag);
  c_race: cover property (tx_load && st_wr);
  c_mrd: cover property (mover_rx_rd && rx_full_flag);
endmodule : ssf_checker
bind ssf_top ssf_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .tx_load(tx_load), .rx_done(rx_done), .mover_tx_wr(mover_tx_wr),
  .mover_rx_rd(mover_rx_rd), .rx_hold_data(rx_hold_data),
  .tx_frame_mp(tx_frame_mp), .tx_enable(tx_enable),
  .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
  .rx_hold_irq(rx_hold_irq));

// ==== ssf_top_test.sv ====
// Self-checking bench for the serial status flag block.
// Assumes ssf_station as line partner and the bound port checker.
`timescale 1ns/10ps
module ssf_top_test
  import ssf_pkg::*;
;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0, rd_p = 0;
  logic tx_load = 0, tx_last_bit = 0, mover_tx_wr = 0, mover_rx_rd = 0;
  logic [SSF_AW-1:0] reg_addr = '0;
  logic [SSF_DW-1:0] reg_wdata = '0, mover_tx_data = '0, d, d2, reg_rdata;
  logic [SSF_DW-1:0] tx_hold_data, rx_hold_data, exq[$];
  logic rx_done, tx_frame_mp, tx_enable, tx_empty_flag, rx_full_flag;
  logic tx_hold_irq, rx_hold_irq, irq;
  ssf_rx_frame_t frm = '0, rx_frame;
  logic [31:0] seed = 32'hf48a83e9;
  int bad_count = 0, n_compared = 0;
  ssf_top u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
    .rx_done(rx_done), .rx_frame(rx_frame), .mover_tx_wr(mover_tx_wr),
    .mover_tx_data(mover_tx_data), .mover_rx_rd(mover_rx_rd),
    .tx_hold_data(tx_hold_data), .rx_hold_data(rx_hold_data),
    .tx_frame_mp(tx_frame_mp), .tx_enable(tx_enable),
    .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
    .tx_hold_irq(tx_hold_irq), .rx_hold_irq(rx_hold_irq), .irq(irq));
  ssf_station u_sta (.sys_clk(sys_clk), .go(go), .frm(frm),
    .rx_done(rx_done), .rx_frame(rx_frame));
  // Free-running 125 MHz clock.
  initial forever #4 sys_clk = ~sys_clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk) reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk) reg_wr <= 0;
  endtask : wr
  // The expected value is noted now and compared when the data appear.
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk) reg_rd <= 1;
    reg_addr <= a;
    exq.push_back(e);
    @(posedge sys_clk) reg_rd <= 0;
  endtask : rd
  task automatic fr(input logic [7:0] v, input logic p, s, m);
    @(posedge sys_clk) go <= 1;
    frm <= '{v, p, s, m};
    @(posedge sys_clk) go <= 0;
    for (int i = 0; i < 20 && rx_done !== 1'b1; i++) @(posedge sys_clk);
    #1;
  endtask : fr
  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge sys_clk) begin
    if (rd_p) check(reg_rdata, exq.pop_front());
    rd_p <= reg_rd;
  end
  // Cuts a hang short well beyond the roughly 140 cycles the run needs.
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    conclude();
  end
  // Main sequence: transmit flags, receive flags, interrupts, disable.
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 0;
    rd(3'h0, 8'h84);
    rd(3'h1, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'h01);
    #1 check(tx_enable, 1'b1);
    check(tx_hold_irq, 1'b1);
    rd(3'h0, 8'h84);
    wr(3'h0, 8'hf8);
    rd(3'h0, 8'h84);
    wr(3'h0, 8'h00);
    #1 check(tx_hold_irq, 1'b0);
    rd(3'h0, 8'h00);
    @(posedge sys_clk) tx_last_bit <= 1;
    @(posedge sys_clk) tx_last_bit <= 0;
    tx_load <= 1;
    @(posedge sys_clk) tx_load <= 0;
    rd(3'h0, 8'h80);
    @(posedge sys_clk) tx_last_bit <= 1;
    @(posedge sys_clk) tx_last_bit <= 0;
    rd(3'h0, 8'h84);
    @(posedge sys_clk) reg_wr <= 1;
    reg_addr <= 3'h0;
    reg_wdata <= 8'h00;
    tx_load <= 1;
    @(posedge sys_clk) reg_wr <= 0;
    tx_load <= 0;
    #1 check(tx_empty_flag, 1'b1);
    d = rnd();
    @(posedge sys_clk) mover_tx_wr <= 1;
    mover_tx_data <= d;
    @(posedge sys_clk) mover_tx_wr <= 0;
    #1 check(tx_hold_data, d);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'h01);
    #1 check(tx_frame_mp, 1'b1);
    wr(3'h0, 8'h00);
    #1 check(tx_frame_mp, 1'b0);
    wr(3'h2, 8'h07);
    d = rnd();
    fr(d, ~^d, 1'b1, 1'b1);
    check(rx_hold_data, d);
    rd(3'h0, 8'h42);
    // The lost frame carries good odd parity so only overrun can rise.
    d2 = rnd();
    fr(d2, ~^d2, 1'b1, 1'b0);
    check(rx_hold_data, d);
    rd(3'h0, 8'h60);
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    d = rnd();
    fr(d, ^d, 1'b1, 1'b0);
    rd(3'h0, 8'h08);
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    fr(d, ~^d, 1'b0, 1'b0);
    rd(3'h0, 8'h10);
    wr(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h2, 8'h05);
    fr(d, ^d, 1'b1, 1'b0);
    check(rx_full_flag, 1'b1);
    @(posedge sys_clk) mover_rx_rd <= 1;
    @(posedge sys_clk) mover_rx_rd <= 0;
    #1 check(rx_full_flag, 1'b0);
    wr(3'h5, 8'hff);
    wr(3'h6, 8'h04);
    #1 check(irq, 1'b0);
    fr(d, ^d, 1'b1, 1'b0);
    check(irq, 1'b1);
    wr(3'h6, 8'h00);
    #1 check(irq, 1'b0);
    wr(3'h6, 8'h04);
    #1 check(irq, 1'b1);
    wr(3'h5, 8'h04);
    #1 check(irq, 1'b0);
    wr(3'h1, 8'h00);
    #1 check(tx_enable, 1'b0);
    @(posedge sys_clk);
    #1 check(tx_empty_flag, 1'b1);
    rd(3'h0, 8'hc4);
    // Disabling the transmitter raised tx empty and tx done events.
    rd(3'h5, 8'h03);
    rd(3'h6, 8'h04);
    rd(3'h4, d);
    wr(3'h3, 8'h5a);
    rd(3'h3, 8'h5a);
    // Parity check and multiproc format off: bad parity and mp 1 ignored.
    @(posedge sys_clk) mover_rx_rd <= 1;
    @(posedge sys_clk) mover_rx_rd <= 0;
    wr(3'h2, 8'h00);
    fr(d, ~^d, 1'b1, 1'b1);
    rd(3'h0, 8'hc4);
    repeat (3) @(posedge sys_clk);
    conclude();
  end
endmodule : ssf_top_test
